// file: design/sfd_decoder.sv
// Serial flash instruction front end: framing, decode, read streaming
`timescale 1ns/100ps
`include "sfd_params.svh"
module sfd_decoder
  import sfd_pkg::*;
#(
  parameter logic [7:0] MAKER_ID  = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'ha5  // Arbitrary value
)
(
  input  wire logic                   clock_in,        // 10 MHz clock
  input  wire logic                   srst_in,         // Sync reset, high
  input  wire logic                   sck_in,          // Serial clock pin
  input  wire logic                   cs_n_in,         // Select pin, low
  input  wire logic                   si_in,           // Serial data in
  output logic                        so_out,          // Serial data out
  output logic                        so_oe_out,       // Drive enable
  output logic [`SFD_ADDR_W-1:0]      rd_addr_out,     // Array read addr
  input  wire logic [7:0]             rd_data_in,      // Array read data
  input  wire logic [7:0]             status_in,       // Status byte
  output logic                        cmd_valid_out,   // Command ready
  input  wire logic                   cmd_ready_in,    // Executor takes it
  output logic [7:0]                  cmd_op_out,      // Command opcode
  output logic [`SFD_ADDR_W-1:0]      cmd_addr_out,    // Command address
  output logic [7:0]                  cmd_data_out,    // Command data
  output logic                        cmd_has_addr_out // Address present
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic len_ok(input logic [7:0] op,
                                  input logic [2:0] n);
    case (op)
      `SFD_OP_WL_SET, `SFD_OP_WL_CLR,
      `SFD_OP_STAT_WEN, `SFD_OP_CE: len_ok = (n == `SFD_LEN_ONE);
      `SFD_OP_STAT_WR:              len_ok = (n == `SFD_LEN_TWO);
      `SFD_OP_SE, `SFD_OP_BE:       len_ok = (n == `SFD_LEN_ADDR);
      `SFD_OP_BP:                   len_ok = (n == `SFD_LEN_DATA);
      `SFD_OP_AUTO_INC:             len_ok = (n == `SFD_LEN_TWO) ||
                                             (n == `SFD_LEN_DATA);
      default:                      len_ok = 1'b0;
    endcase
  endfunction

  function automatic logic is_id(input logic [7:0] op);
    is_id = (op == `SFD_OP_ID_A) || (op == `SFD_OP_ID_B);
  endfunction

  function automatic logic is_known(input logic [7:0] op);
    is_known = len_ok(op, `SFD_LEN_ONE) || len_ok(op, `SFD_LEN_TWO) ||
               len_ok(op, `SFD_LEN_ADDR) || len_ok(op, `SFD_LEN_DATA) ||
               is_id(op) || (op == `SFD_OP_READ) ||
               (op == `SFD_OP_FREAD) || (op == `SFD_OP_STAT_RD);
  endfunction

  sfd_state_reg_t r_reg;
  sfd_state_reg_t r_next;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_fall;
  logic           cs_rise;
  logic [7:0]     nb;

  // Edge detection on synchronised pins
  assign sck_rise = r_reg.sck_s & ~r_reg.sck_d;
  assign sck_fall = ~r_reg.sck_s & r_reg.sck_d;
  assign cs_fall  = ~r_reg.cs_s & r_reg.cs_d;
  assign cs_rise  = r_reg.cs_s & ~r_reg.cs_d;
  assign nb       = {r_reg.sh[6:0], r_reg.si_s};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] src;
    src    = rd_data_in;
    r_next = r_reg;
    // Two-flop synchronisers, first stage read only by the second
    r_next.sck_m = sck_in;
    r_next.sck_s = r_reg.sck_m;
    r_next.sck_d = r_reg.sck_s;
    r_next.cs_m  = cs_n_in;
    r_next.cs_s  = r_reg.cs_m;
    r_next.cs_d  = r_reg.cs_s;
    r_next.si_m  = si_in;
    r_next.si_s  = r_reg.si_m;

    // Frame start; a pending command blocks it
    if (cs_fall && !r_reg.pend)
    begin
      r_next.st       = SFD_RX;
      r_next.bit_cnt  = 3'h0;
      r_next.byte_cnt = 3'h0;
    end
    else if (r_reg.st == SFD_RX && sck_rise)
    begin
      r_next.sh      = nb;
      r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
      if (r_reg.bit_cnt == `SFD_BIT_LAST)
      begin
        if (r_reg.byte_cnt != `SFD_CNT_MAX)
          r_next.byte_cnt = r_reg.byte_cnt + 3'h1;
        if (r_reg.byte_cnt == `SFD_IDX_OP)
        begin
          r_next.op = nb;
          if (!is_known(nb))
            r_next.st = SFD_DEAD;
          else if (nb == `SFD_OP_STAT_RD)
            r_next.st = SFD_STREAM;
        end
        else if (r_reg.byte_cnt <= `SFD_IDX_A_LO)
        begin
          r_next.addr = {r_reg.addr[15:0], nb};
          r_next.data = nb;
          if (r_reg.byte_cnt == `SFD_IDX_A_LO)
          begin
            r_next.idsel   = nb[0];
            r_next.rd_addr = r_next.addr[`SFD_TOP_BIT:0];
            if (r_reg.op == `SFD_OP_READ || is_id(r_reg.op))
              r_next.st = SFD_STREAM;
          end
        end
        else if (r_reg.byte_cnt == `SFD_IDX_DUMMY)
        begin
          r_next.data = nb;
          if (r_reg.op == `SFD_OP_FREAD)
            r_next.st = SFD_STREAM;
        end
      end
    end
    else if (r_reg.st == SFD_STREAM && sck_fall)
    begin
      // Output byte source, chosen at each byte boundary
      if (r_reg.op == `SFD_OP_STAT_RD)
        src = status_in;
      else if (is_id(r_reg.op))
        src = r_reg.idsel ? DEVICE_ID : MAKER_ID;
      r_next.oe      = 1'b1;
      r_next.out_cnt = r_reg.out_cnt + 3'h1;
      if (r_reg.out_cnt == 3'h0)
      begin
        r_next.so     = src[7];
        r_next.out_sh = {src[6:0], 1'b0};
        if (is_id(r_reg.op))
          r_next.idsel = ~r_reg.idsel;
        else if (r_reg.op != `SFD_OP_STAT_RD)
          r_next.rd_addr = r_reg.rd_addr + 1'b1;
      end
      else
      begin
        r_next.so     = r_reg.out_sh[7];
        r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
      end
    end

    // Frame end: execute only whole, well-formed instructions
    if (cs_rise)
    begin
      r_next.st      = SFD_IDLE;
      r_next.oe      = 1'b0;
      r_next.out_cnt = 3'h0;
      if (r_reg.st == SFD_RX && r_reg.bit_cnt == 3'h0 &&
          len_ok(r_reg.op, r_reg.byte_cnt))
        r_next.pend = 1'b1;
    end

    // Two-entry buffer: pop the head, then load the pending command
    if (r_reg.cnt != 2'h0 && cmd_ready_in)
    begin
      r_next.fifo[0] = r_reg.fifo[1];
      r_next.cnt     = r_reg.cnt - 2'h1;
    end
    if (r_reg.pend && r_next.cnt != 2'h2)
    begin
      r_next.fifo[r_next.cnt[0]].op       = r_reg.op;
      r_next.fifo[r_next.cnt[0]].addr     = r_reg.addr[`SFD_TOP_BIT:0];
      r_next.fifo[r_next.cnt[0]].data     = r_reg.data;
      // Only frames long enough to carry three address bytes have one
      r_next.fifo[r_next.cnt[0]].has_addr = (r_reg.byte_cnt >=
                                             `SFD_LEN_ADDR);
      r_next.cnt  = r_next.cnt + 2'h1;
      r_next.pend = 1'b0;
    end
    r_next.vld = (r_next.cnt != 2'h0);
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      r_reg       <= '0;
      r_reg.cs_m  <= 1'b1;
      r_reg.cs_s  <= 1'b1;
      r_reg.cs_d  <= 1'b1;
      r_reg.st    <= SFD_IDLE;
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from the state register
  assign so_out           = r_reg.so;
  assign so_oe_out        = r_reg.oe;
  assign rd_addr_out      = r_reg.rd_addr;
  assign cmd_valid_out    = r_reg.vld;
  assign cmd_op_out       = r_reg.fifo[0].op;
  assign cmd_addr_out     = r_reg.fifo[0].addr;
  assign cmd_data_out     = r_reg.fifo[0].data;
  assign cmd_has_addr_out = r_reg.fifo[0].has_addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_whole_bytes: assert property (
    @(posedge clock_in) disable iff (srst_in)
    $rose(r_reg.pend) |-> $past(r_reg.bit_cnt) == 3'h0)
    else $error("command issued mid byte");
  chk_start_fall: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st != SFD_RX) ##1 (r_reg.st == SFD_RX) |-> $past(cs_fall))
    else $error("frame began without select fall");
  chk_msb_first: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st == SFD_RX && sck_rise && !cs_fall && r_reg.bit_cnt == 3'h7
     && r_reg.byte_cnt == 3'h0) |=> r_reg.op[0] == $past(r_reg.si_s))
    else $error("opcode bit order wrong");
  chk_abort_mid: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (cs_rise && r_reg.st == SFD_RX && r_reg.bit_cnt != 3'h0)
    |=> !r_reg.pend)
    else $error("partial byte executed");
  chk_auto_len: assert property (
    @(posedge clock_in) disable iff (srst_in)
    ($rose(r_reg.pend) && r_reg.op == `SFD_OP_AUTO_INC)
    |-> (r_reg.byte_cnt == 3'h2 || r_reg.byte_cnt == 3'h5))
    else $error("auto-increment program length wrong");
  chk_id_byte: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st == SFD_STREAM && sck_fall && !cs_rise && r_reg.out_cnt == 3'h0
     && is_id(r_reg.op)) |=> r_reg.so ==
     ($past(r_reg.idsel) ? DEVICE_ID[7] : MAKER_ID[7]))
    else $error("identifier bit wrong");
  chk_read_wrap: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st == SFD_STREAM && sck_fall && !cs_rise && r_reg.out_cnt == 3'h0
     && r_reg.op == `SFD_OP_READ && (&r_reg.rd_addr))
     |=> r_reg.rd_addr == '0)
    else $error("read address did not wrap");
  chk_fast_dummy: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st == SFD_RX && sck_rise && !cs_fall && !cs_rise
     && r_reg.bit_cnt == 3'h7 && r_reg.byte_cnt == 3'h3
     && r_reg.op == `SFD_OP_FREAD) |=> r_reg.st == SFD_RX)
    else $error("fast read skipped its dummy byte");
  chk_status_rep: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (r_reg.st == SFD_STREAM && sck_fall && !cs_rise && r_reg.out_cnt == 3'h0
     && r_reg.op == `SFD_OP_STAT_RD)
    |=> r_reg.so == $past(status_in[7]))
    else $error("status byte not repeated");
endmodule

// file: design/sfd_params.svh
// Constants for the serial flash instruction decoder
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH
`define SFD_OP_READ      8'h03
`define SFD_OP_FREAD     8'h0b
`define SFD_OP_SE        8'h20
`define SFD_OP_BE        8'h52
`define SFD_OP_CE        8'h60
`define SFD_OP_BP        8'h02
`define SFD_OP_AUTO_INC  8'haf
`define SFD_OP_STAT_RD   8'h05
`define SFD_OP_STAT_WEN  8'h50
`define SFD_OP_STAT_WR   8'h01
`define SFD_OP_WL_SET    8'h06
`define SFD_OP_WL_CLR    8'h04
`define SFD_OP_ID_A      8'h90
`define SFD_OP_ID_B      8'hab
`define SFD_BIT_LAST     3'h7
`define SFD_CNT_MAX      3'h7
`define SFD_LEN_ONE      3'h1
`define SFD_LEN_TWO      3'h2
`define SFD_LEN_ADDR     3'h4
`define SFD_LEN_DATA     3'h5
`define SFD_IDX_OP       3'h0
`define SFD_IDX_A_LO     3'h3
`define SFD_IDX_DUMMY    3'h4
`define SFD_TOP_BIT      17
`define SFD_ADDR_W       18
`endif

// file: design/sfd_pkg.sv
// Types for the serial flash instruction decoder
`include "sfd_params.svh"
package sfd_pkg;
  typedef enum logic [1:0]
  {
    SFD_IDLE   = 2'h0,
    SFD_RX     = 2'h1,
    SFD_STREAM = 2'h3,
    SFD_DEAD   = 2'h2
  } sfd_state_t;

  typedef struct packed
  {
    logic [7:0]               op;
    logic [`SFD_ADDR_W-1:0]   addr;
    logic [7:0]               data;
    logic                     has_addr;
  } sfd_entry_t;

  typedef struct packed
  {
    logic                     sck_m, sck_s, sck_d;
    logic                     cs_m, cs_s, cs_d;
    logic                     si_m, si_s;
    sfd_state_t               st;
    logic [2:0]               bit_cnt;
    logic [2:0]               byte_cnt;
    logic [7:0]               sh;
    logic [7:0]               op;
    logic [23:0]              addr;
    logic [7:0]               data;
    logic                     idsel;
    logic [7:0]               out_sh;
    logic [2:0]               out_cnt;
    logic [`SFD_ADDR_W-1:0]   rd_addr;
    logic                     so;
    logic                     oe;
    logic                     pend;
    sfd_entry_t [1:0]         fifo;
    logic [1:0]               cnt;
    logic                     vld;
  } sfd_state_reg_t;
endpackage

// file: verification/sfd_spi_host.sv
// SPI host model that frames instructions on the decoder's serial pins
`timescale 1ns/100ps
module sfd_spi_host (
  input  wire logic clock_in, // System clock
  input  wire logic so_in,    // Serial data from device
  output logic      sck_out,  // Serial clock, idles low
  output logic      cs_n_out, // Select, active low
  output logic      si_out    // Serial data to device
);
  // Clocks per serial half period; raise it for a slow host
  int half = 4;

  // Idle levels at time zero
  initial
  begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
  end

  // Waits a number of falling system clock edges
  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Shifts n bits of tx out, MSB first; samples so at each rise
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck_out = 1'b0;
      si_out  = tx[i];
      wt(half);
      sck_out = 1'b1;
      rx[i]   = so_in;
      wt(half);
    end
  endtask

  // Lowers select before the first bit
  task automatic start;
    cs_n_out = 1'b0;
    wt(2);
  endtask

  // Parks the clock, raises select and lets si drift off its last value
  task automatic stop;
    wt(2);
    sck_out = 1'b0;
    wt(2);
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    wt(8);
  endtask
endmodule

// file: verification/sfd_decoder_bench.sv
// Self-checking bench for the serial flash instruction decoder
`timescale 1ns/100ps
`include "sfd_params.svh"
module sfd_decoder_bench;
  localparam logic [7:0] MK = 8'h3e; // Arbitrary maker value
  localparam logic [7:0] DV = 8'hc1; // Arbitrary device value
  localparam logic [47:0] FV [10] = '{48'h060000000000, 48'h207a5a5a0000,
    48'h52c3c0010000, 48'h02012345a700, 48'haffffff05e00,
    48'haf8100000000, 48'h600000000000, 48'h040000000000,
    48'h500000000000, 48'h013c00000000};
  localparam int FN [10] = '{1, 4, 4, 5, 5, 2, 1, 1, 1, 2};
  logic                   clock_in  = 1'b0;
  logic                   srst_in   = 1'b1;
  logic                   cmd_ready = 1'b0;
  logic [7:0]             status    = 8'h96;
  logic                   sck, cs_n, si, so, so_oe, cmd_valid, cmd_has;
  logic [7:0]             cmd_op, cmd_data, rx;
  logic [`SFD_ADDR_W-1:0] rd_addr, cmd_addr;
  wire logic [7:0]        rd_data = rd_addr[7:0] ^ 8'h3c; // Array model
  wire logic              so_pin  = so_oe ? so : ~so; // Released line flips
  int                     n_errors  = 0;
  int                     cmp_count = 0;

  always #50 clock_in = ~clock_in;

  sfd_spi_host i_host (.clock_in(clock_in), .so_in(so_pin), .sck_out(sck),
    .cs_n_out(cs_n), .si_out(si));
  sfd_decoder #(.MAKER_ID(MK), .DEVICE_ID(DV)) i_dut (.clock_in(clock_in),
    .srst_in(srst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(so_oe), .rd_addr_out(rd_addr),
    .rd_data_in(rd_data), .status_in(status), .cmd_valid_out(cmd_valid),
    .cmd_ready_in(cmd_ready), .cmd_op_out(cmd_op), .cmd_addr_out(cmd_addr),
    .cmd_data_out(cmd_data), .cmd_has_addr_out(cmd_has));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Sends one framed instruction; the last byte may be cut short
  task automatic send(input logic [47:0] v, input int n, input int nb);
    i_host.start();
    for (int k = 0; k < n; k++)
      i_host.xfer(v[47-8*k -: 8], (k == n - 1) ? nb : 8, rx);
    i_host.stop();
  endtask

  // Waits for the head command, compares it and accepts it
  task automatic take(input logic [47:0] v, input int n);
    int w;
    w = 0;
    while (cmd_valid !== 1'b1 && w < 40)
    begin
      @(negedge clock_in);
      w++;
    end
    check(cmd_valid, 1'b1);
    if (cmd_valid !== 1'b1)
      conclude();
    check(cmd_op, v[47:40]);
    check(cmd_has, n >= 4);
    if (n >= 4)
      check(cmd_addr, v[33:16]);
    if (n == 2 || n == 5)
      check(cmd_data, (n == 5) ? v[15:8] : v[39:32]);
    cmd_ready = 1'b1;
    @(negedge clock_in);
    cmd_ready = 1'b0;
    // Let an edge pass so a following call never re-raises ready at once
    @(negedge clock_in);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read(input logic [7:0] op, input logic [23:0] a);
    logic [`SFD_ADDR_W-1:0] ea;
    ea = a[17:0];
    i_host.start();
    i_host.xfer(op, 8, rx);
    for (int k = 0; k < 3; k++)
      i_host.xfer(a[23-8*k -: 8], 8, rx);
    check(rd_addr, ea);
    if (op == `SFD_OP_FREAD)
      i_host.xfer(8'h00, 8, rx);
    for (int k = 0; k < 3; k++)
    begin
      i_host.xfer(8'h00, 8, rx);
      check(rx, ea[7:0] ^ 8'h3c);
      ea = ea + 18'h1;
    end
    check(so_oe, 1'b1);
    i_host.stop();
    check(so_oe, 1'b0);
  endtask

  task automatic t_status;
    i_host.start();
    i_host.xfer(`SFD_OP_STAT_RD, 8, rx);
    for (int k = 0; k < 3; k++)
    begin
      i_host.xfer(8'h00, 8, rx);
      check(rx, status);
    end
    i_host.stop();
  endtask

  task automatic t_id(input logic [7:0] op, input logic sel,
                      input logic [7:0] e0, input logic [7:0] e1);
    send({op, 16'h0000, 7'h00, sel, 16'h0000}, 4, 8);
    i_host.start();
    i_host.xfer(op, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.xfer({7'h00, sel}, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    check(rx, e0);
    i_host.xfer(8'h00, 8, rx);
    check(rx, e1);
    i_host.stop();
  endtask

  // Cut frames, wrong count and clocks without select leave nothing
  task automatic t_abort;
    send(FV[0], 1, 5);
    send(FV[1], 3, 8);
    send(FV[1], 4, 3);
    send({8'h77, 40'h0}, 2, 8);
    i_host.xfer(8'h06, 8, rx);
    i_host.stop();
    check(cmd_valid, 1'b0);
    send(FV[0], 1, 8);
    take(FV[0], 1);
  endtask

  // Fill the two-entry buffer plus a pending one, refuse the next, drain
  task automatic t_buffer;
    send(FV[0], 1, 8);
    send(FV[7], 1, 8);
    send(FV[6], 1, 8);
    send(FV[8], 1, 8);
    check(cmd_op, 8'h06);
    take(FV[0], 1);
    take(FV[7], 1);
    take(FV[6], 1);
    repeat (10) @(negedge clock_in);
    check(cmd_valid, 1'b0);
  endtask

  initial
  begin
    repeat (4) @(negedge clock_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    check(cmd_valid, 1'b0);
    t_read(`SFD_OP_READ, 24'hfffffe);
    t_read(`SFD_OP_FREAD, 24'h4c0010);
    t_status();
    t_id(`SFD_OP_ID_A, 1'b0, MK, DV);
    t_id(`SFD_OP_ID_B, 1'b1, DV, MK);
    // Latch set leads the table; status write follows its enable
    for (int i = 0; i < 10; i++)
    begin
      send(FV[i], FN[i], 8);
      take(FV[i], FN[i]);
    end
    t_abort();
    t_buffer();
    conclude();
  end
endmodule
